// ---- rtl/buck_protection_sequencer.sv ----
// Purpose: switch sequencing and protection of a step-down converter
// Assumes: comparator flags are asynchronous; OSC_TICK is MCLK-synchronous
// Notes:   one MCLK of dead time between the two switch enables
`include "buck_seq_map.svh"
module buck_protection_sequencer
  import buck_seq_pkg::*;
#(
  parameter int OVL_LIMIT     = `OVL_LIMIT,
  parameter int HICCUP_CYCLES = `HICCUP_CYCLES
) (
  // Clock and reset
  input  wire logic MCLK,
  input  wire logic NRST,
  // Frequency set or sync pin, internal oscillator
  input  wire logic FREQ_SET_OR_SYNC,
  input  wire logic OSC_TICK,
  // Feedback comparators
  input  wire logic FEEDBACK_SENSE_IN_WIN,
  input  wire logic FEEDBACK_SENSE_LOW,
  input  wire logic FEEDBACK_SENSE_HIGH,
  input  wire logic OUTPUT_OVERVOLT_GUARD,
  // Current comparators
  input  wire logic PEAK_TRIP,
  input  wire logic LS_SRC_TRIP,
  input  wire logic LS_SINK_TRIP,
  input  wire logic LS_REVERSE,
  input  wire logic OVERLOAD,
  // Supervisors
  input  wire logic OVER_TEMP,
  input  wire logic LOW_INPUT_LOCKOUT,
  input  wire logic EN_OK,
  // Soft ramp comparators
  input  wire logic SOFT_RAMP_TRACK_PG,
  input  wire logic SOFT_RAMP_TRACK_LOW,
  input  wire logic SOFT_RAMP_TRACK_GND,
  // Switch enables
  output logic      HS_EN,
  output logic      LS_EN,
  // Power good, open drain
  output logic      OUTPUT_OK_FLAG_O,
  output logic      OUTPUT_OK_FLAG_OE,
  // Soft ramp and status
  output logic      SOFT_RAMP_DISCHARGE,
  output logic      REF_FROM_SOFT_RAMP,
  output logic      SINK_ALLOW,
  output logic      EXT_CLK_MODE,
  output logic      PLL_LOCKED,
  output logic      HICCUP_ACTIVE
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  flags_type f_raw;
  flags_type f;

  assign f_raw = '{
    clk_pin:  FREQ_SET_OR_SYNC,
    fb_win:   FEEDBACK_SENSE_IN_WIN,
    fb_low:   FEEDBACK_SENSE_LOW,
    fb_high:  FEEDBACK_SENSE_HIGH,
    overvolt: OUTPUT_OVERVOLT_GUARD,
    peak:     PEAK_TRIP,
    ls_src:   LS_SRC_TRIP,
    ls_sink:  LS_SINK_TRIP,
    ls_rev:   LS_REVERSE,
    overload: OVERLOAD,
    hot:      OVER_TEMP,
    lockout:  LOW_INPUT_LOCKOUT,
    en_ok:    EN_OK,
    ramp_pg:  SOFT_RAMP_TRACK_PG,
    ramp_low: SOFT_RAMP_TRACK_LOW,
    ramp_gnd: SOFT_RAMP_TRACK_GND
  };

  sync2 #(
    .W (`FLAG_W)
  ) u_sync (
    .clk   (MCLK),
    .rst_n (NRST),
    .d     (f_raw),
    .q     (f)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam logic [`OVL_W-1:0] OVL_MAX = `OVL_W'(OVL_LIMIT);
  localparam logic [`HIC_W-1:0] HIC_MAX = `HIC_W'(HICCUP_CYCLES - 1);
  localparam logic [`PER_W-1:0] PER_TOL = `PLL_TOL;

  st_type           st_q;
  st_type           st_d;
  logic             clk_rise;
  logic             clk_fall;
  logic             cyc;
  logic             shut;
  logic             pg_hold;
  logic [`PER_W-1:0] per_diff;

  // Edges are taken from the second synchroniser stage only
  assign clk_rise = f.clk_pin & ~st_q.clk_prev;
  assign clk_fall = ~f.clk_pin & st_q.clk_prev;
  // Cycle start source; sticky, so no fallback glitch to the oscillator
  assign cyc      = st_q.ext ? clk_fall : OSC_TICK;
  assign shut     = f.lockout | ~f.en_ok;
  assign pg_hold  = shut | f.hot | ~f.ramp_pg;
  assign per_diff = (st_q.per_cnt > st_q.per_prev) ?
                    st_q.per_cnt - st_q.per_prev :
                    st_q.per_prev - st_q.per_cnt;

  always_comb begin
    st_d          = st_q;
    st_d.clk_prev = f.clk_pin;

    // ----------------------------------------
    // Clock mode detection and period tracking
    // ----------------------------------------
    st_d.ext = st_q.ext | clk_rise;
    if (clk_fall) begin
      st_d.per_prev = st_q.per_cnt;
      st_d.per_cnt  = '0;
      st_d.lock     = st_q.ext & (per_diff <= PER_TOL);
    end else if (st_q.per_cnt != '1) begin
      st_d.per_cnt = st_q.per_cnt + `PER_W'(1);
    end else begin
      // A stalled clock drops the lock
      st_d.lock = 1'b0;
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    case (st_q.mode)
      ST_OFF: begin
        if (!shut) begin
          st_d.mode = f.hot ? ST_HOT : ST_DISCH;
        end
      end
      ST_HOT: begin
        if (!f.hot) begin
          st_d.mode    = ST_HICC;
          st_d.hic_cnt = '0;
        end
      end
      ST_HICC: begin
        if (f.hot) begin
          st_d.mode = ST_HOT;
        end else if (cyc) begin
          if (st_q.hic_cnt == HIC_MAX) begin
            st_d.mode = ST_DISCH;
          end else begin
            st_d.hic_cnt = st_q.hic_cnt + `HIC_W'(1);
          end
        end
      end
      ST_DISCH: begin
        if (f.hot) begin
          st_d.mode = ST_HOT;
        end else if (f.ramp_gnd) begin
          st_d.mode = ST_RUN;
        end
      end
      ST_RUN: begin
        if (f.hot) begin
          st_d.mode = ST_HOT;
        end else if (cyc) begin
          if (!f.overload) begin
            st_d.ovl_cnt = '0;
          end else if (st_q.ovl_cnt == OVL_MAX) begin
            st_d.mode    = ST_HICC;
            st_d.hic_cnt = '0;
          end else begin
            st_d.ovl_cnt = st_q.ovl_cnt + `OVL_W'(1);
          end
        end
      end
      default: begin
        st_d.mode = ST_OFF;
      end
    endcase
    // Lockout and enable override every other state
    if (shut) begin
      st_d.mode = ST_OFF;
    end
    if (st_d.mode != ST_RUN) begin
      st_d.ovl_cnt = '0;
    end

    // ----------------------------------------
    // Switching phase
    // ----------------------------------------
    if (st_d.mode != ST_RUN) begin
      st_d.phase = PH_OFF;
    end else if (cyc) begin
      // Turn-on only here, so recovery waits for a cycle start
      if (f.overvolt || f.ls_src) begin
        st_d.phase = PH_LS;
      end else begin
        st_d.phase = PH_HS;
      end
    end else begin
      case (st_q.phase)
        PH_HS: begin
          if (f.peak || f.overvolt) begin
            st_d.phase = PH_LS;
          end
        end
        PH_LS: begin
          if (f.ls_sink || (f.ls_rev && !st_q.sink_ok)) begin
            st_d.phase = PH_OFF;
          end
        end
        default: begin
          st_d.phase = PH_OFF;
        end
      endcase
    end
    // Break before make: an enable rises only once the other is low
    st_d.hs = (st_d.phase == PH_HS) & ~st_q.ls;
    st_d.ls = (st_d.phase == PH_LS) & ~st_q.hs;

    // ----------------------------------------
    // Power good with hysteresis
    // ----------------------------------------
    if (pg_hold || (st_d.mode != ST_RUN)) begin
      st_d.pg_low = 1'b1;
    end else if (f.fb_low || f.fb_high) begin
      st_d.pg_low = 1'b1;
    end else if (f.fb_win) begin
      st_d.pg_low = 1'b0;
    end

    // ----------------------------------------
    // Soft ramp control
    // ----------------------------------------
    st_d.discharge = (st_d.mode != ST_RUN);
    st_d.ref_ss    = f.ramp_low;
    st_d.sink_ok   = f.ramp_pg;
    st_d.hiccup    = (st_d.mode == ST_HICC);
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      st_q <= '{mode: ST_OFF, phase: PH_OFF, discharge: 1'b1,
                pg_low: 1'b1, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign HS_EN               = st_q.hs;
  assign LS_EN               = st_q.ls;
  // Open drain: only ever pulls low
  assign OUTPUT_OK_FLAG_O    = 1'b0;
  assign OUTPUT_OK_FLAG_OE   = st_q.pg_low;
  assign SOFT_RAMP_DISCHARGE = st_q.discharge;
  assign REF_FROM_SOFT_RAMP  = st_q.ref_ss;
  assign SINK_ALLOW          = st_q.sink_ok;
  assign EXT_CLK_MODE        = st_q.ext;
  assign PLL_LOCKED          = st_q.lock;
  assign HICCUP_ACTIVE       = st_q.hiccup;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_NO_OVERLAP: assert property (
    @(posedge MCLK) disable iff (!NRST)
    !(HS_EN && LS_EN))
    else $error("both switch enables high");

  AST_DEAD_TIME: assert property (
    @(posedge MCLK) disable iff (!NRST)
    $rose(HS_EN) |-> !$past(LS_EN))
    else $error("high side rose without dead time");

  AST_OVERVOLT_HS: assert property (
    @(posedge MCLK) disable iff (!NRST)
    f.overvolt |=> !HS_EN)
    else $error("high side on during overvoltage");

  AST_HS_AT_CYCLE: assert property (
    @(posedge MCLK) disable iff (!NRST)
    $rose(HS_EN) |-> ($past(cyc) || $past(cyc, 2)))
    else $error("high side turned on off a cycle start");

  AST_SRC_SKIP: assert property (
    @(posedge MCLK) disable iff (!NRST)
    (cyc && f.ls_src) |=> !HS_EN)
    else $error("high side pulse not skipped");

  AST_PEAK_OFF: assert property (
    @(posedge MCLK) disable iff (!NRST)
    (HS_EN && f.peak && !cyc && !shut && !f.hot) |=>
      !HS_EN && st_q.phase == PH_LS)
    else $error("peak trip did not hand over to low side");

  AST_SINK_OFF: assert property (
    @(posedge MCLK) disable iff (!NRST)
    (st_q.phase == PH_LS && f.ls_sink && !cyc) |=> !LS_EN && !HS_EN)
    else $error("sink trip left a switch on");

  AST_SHUTDOWN: assert property (
    @(posedge MCLK) disable iff (!NRST)
    (shut || f.hot) |=> !HS_EN && !LS_EN && SOFT_RAMP_DISCHARGE)
    else $error("switching during shutdown");

  AST_PG_HOLD: assert property (
    @(posedge MCLK) disable iff (!NRST)
    pg_hold |=> OUTPUT_OK_FLAG_OE)
    else $error("power good released during hold");

  AST_PG_OUT: assert property (
    @(posedge MCLK) disable iff (!NRST)
    (f.fb_low || f.fb_high) |=> OUTPUT_OK_FLAG_OE)
    else $error("power good released outside window");

  AST_RUN_AFTER_GND: assert property (
    @(posedge MCLK) disable iff (!NRST)
    $rose(st_q.mode == ST_RUN) |-> $past(st_q.mode == ST_DISCH && f.ramp_gnd))
    else $error("switching began before ramp discharge");

  AST_EXT_STICKY: assert property (
    @(posedge MCLK) disable iff (!NRST)
    EXT_CLK_MODE |=> EXT_CLK_MODE)
    else $error("clock mode dropped");

  AST_HICC_EXIT: assert property (
    @(posedge MCLK) disable iff (!NRST)
    $fell(st_q.mode == ST_HICC) |-> st_q.mode != ST_RUN)
    else $error("hiccup skipped the discharge step");

endmodule

// ---- rtl/buck_seq_map.svh ----
// What this block does
// - Seeing an external clock on the sync pin switches permanently to clock mode.
// - In clock mode the switching cycle tracks the external clock period.
// - Reference follows the soft ramp while the ramp is below the reference.
// - Lockout, enable low or overheating stop switching at once.
// - No switching restarts before the soft ramp node reaches ground.
// - Power good pulldown releases when feedback is inside its window.
// - Power good pulls low when feedback leaves the outer window.
// - Power good stays low on lockout, heat, enable low, low ramp.
// - High side stays off while feedback is above overvoltage threshold.
// - High side may return only at the next cycle start.
// - Peak current trip turns high side off and low side on.
// - Low side source limit at cycle end skips the next high side pulse.
// - High side resumes at a cycle start with source current below limit.
// - Low side sink limit turns both switches off until next cycle.
// - Overload beyond 512 cycles shuts down, waits 16384 cycles, restarts.
// - Overtemperature flag stops switching.
// - After cooling, wait 16384 cycles, then full power-up again.
// - Each cycle starts with high side on at the oscillator tick.
// - In clock mode a cycle starts on the external clock falling edge.
// - Low side may not sink until soft ramp exceeds its good level.
//
// Purpose: constants of the converter sequencer
// Assumes: counts are in switching cycles, PLL_TOL in MCLK cycles
// Notes:   widths sized for the default counts
`ifndef BUCK_SEQ_MAP_SVH
`define BUCK_SEQ_MAP_SVH

// ----------------------------------------
// Counts
// ----------------------------------------
`define OVL_LIMIT     512
`define HICCUP_CYCLES 16384
`define PLL_TOL       16'h0002

// ----------------------------------------
// Widths
// ----------------------------------------
`define PER_W 16
`define OVL_W 10
`define HIC_W 15
`define FLAG_W 16

`endif

// ---- rtl/buck_seq_pkg.sv ----
// Purpose: types of the converter sequencer
// Assumes: buck_seq_map.svh gives widths
// Notes:   state codes are one-hot
`include "buck_seq_map.svh"
package buck_seq_pkg;

  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_OFF   = 5'h01,
    ST_HOT   = 5'h02,
    ST_HICC  = 5'h04,
    ST_DISCH = 5'h08,
    ST_RUN   = 5'h10
  } mode_type;

  typedef enum logic [2:0] {
    PH_OFF = 3'h1,
    PH_HS  = 3'h2,
    PH_LS  = 3'h4
  } phase_type;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic clk_pin;
    logic fb_win;
    logic fb_low;
    logic fb_high;
    logic overvolt;
    logic peak;
    logic ls_src;
    logic ls_sink;
    logic ls_rev;
    logic overload;
    logic hot;
    logic lockout;
    logic en_ok;
    logic ramp_pg;
    logic ramp_low;
    logic ramp_gnd;
  } flags_type;

  typedef struct packed {
    mode_type             mode;
    phase_type            phase;
    logic                 hs;
    logic                 ls;
    logic                 pg_low;
    logic                 ext;
    logic                 lock;
    logic                 clk_prev;
    logic [`PER_W-1:0]    per_cnt;
    logic [`PER_W-1:0]    per_prev;
    logic [`OVL_W-1:0]    ovl_cnt;
    logic [`HIC_W-1:0]    hic_cnt;
    logic                 discharge;
    logic                 ref_ss;
    logic                 sink_ok;
    logic                 hiccup;
  } st_type;

endpackage

// ---- rtl/sync2.sv ----
// Purpose: two-stage synchroniser for a bundle of levels
// Assumes: inputs are asynchronous levels
// Notes:   first stage is read by the second only
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// ---- bench/analog_far_side.sv ----
// Purpose: comparator, oscillator and ramp node beside the sequencer
// Assumes: one model step per MCLK
// Notes:   ramp and peak current are crude counters, not analog
module analog_far_side (
  // Clock
  input  wire logic mclk,
  // From sequencer, plus osc_en from the bench
  input  wire logic hs_en,
  input  wire logic discharge,
  input  wire logic osc_en,
  // To sequencer
  output logic      osc_tick,
  output logic      peak,
  output logic      ramp_pg,
  output logic      ramp_low,
  output logic      ramp_gnd
);
  timeunit 1ns;
  timeprecision 1ps;

  int tick_cnt = 0;
  int ramp     = 40;
  int on_cnt   = 0;

  // Drains faster than it charges, as a pulled node would
  always @(posedge mclk) begin
    tick_cnt <= (tick_cnt == 19) ? 0 : tick_cnt + 1;
    if (discharge)
      ramp <= (ramp > 1) ? ramp - 2 : 0;
    else
      ramp <= (ramp < 40) ? ramp + 1 : 40;
    on_cnt <= hs_en ? on_cnt + 1 : 0;
  end

  // Tick stops in clock mode; the sync pin takes over
  assign osc_tick = osc_en && tick_cnt == 19;
  assign peak     = on_cnt >= 6;
  assign ramp_gnd = ramp == 0;
  assign ramp_pg  = ramp >= 30;
  assign ramp_low = ramp < 20;
endmodule

// ---- bench/tb_buck_protection_sequencer.sv ----
// Purpose: self-checking bench of the converter sequencer
// Assumes: far-side model gives ticks, peak and ramp levels
// Notes:   short counts keep overload and hiccup waits brief
module tb_buck_protection_sequencer;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk     = 1'b0;
  logic nrst     = 1'b0;
  logic sync_pin = 1'b0;
  logic sync_on  = 1'b0;
  logic osc_en   = 1'b1;
  logic fb_win   = 1'b0;
  logic fb_low   = 1'b1;
  logic fb_high  = 1'b0;
  logic overvolt = 1'b0;
  logic ls_src   = 1'b0;
  logic ls_sink  = 1'b0;
  logic ls_rev   = 1'b0;
  logic ovl      = 1'b0;
  logic hot      = 1'b0;
  logic lockout  = 1'b0;
  logic en_ok    = 1'b0;
  logic osc_tick, peak, ramp_pg, ramp_low, ramp_gnd;
  logic hs_en, ls_en, ok_o, ok_oe, discharge;
  logic ref_ramp, sink_ok, ext_mode, pll_lock, hiccup;
  int   sync_cnt = 0;
  int   fails    = 0;
  int   compares = 0;

  always #5 mclk = ~mclk;

  always @(posedge mclk) begin
    if (sync_on) begin
      sync_cnt <= (sync_cnt == 29) ? 0 : sync_cnt + 1;
      sync_pin <= sync_cnt < 15;
    end
  end

  buck_protection_sequencer #(.OVL_LIMIT(4), .HICCUP_CYCLES(8)) uut (
    .MCLK(mclk), .NRST(nrst), .FREQ_SET_OR_SYNC(sync_pin),
    .OSC_TICK(osc_tick), .FEEDBACK_SENSE_IN_WIN(fb_win),
    .FEEDBACK_SENSE_LOW(fb_low), .FEEDBACK_SENSE_HIGH(fb_high),
    .OUTPUT_OVERVOLT_GUARD(overvolt), .PEAK_TRIP(peak),
    .LS_SRC_TRIP(ls_src), .LS_SINK_TRIP(ls_sink), .LS_REVERSE(ls_rev),
    .OVERLOAD(ovl), .OVER_TEMP(hot), .LOW_INPUT_LOCKOUT(lockout),
    .EN_OK(en_ok), .SOFT_RAMP_TRACK_PG(ramp_pg),
    .SOFT_RAMP_TRACK_LOW(ramp_low), .SOFT_RAMP_TRACK_GND(ramp_gnd),
    .HS_EN(hs_en), .LS_EN(ls_en), .OUTPUT_OK_FLAG_O(ok_o),
    .OUTPUT_OK_FLAG_OE(ok_oe), .SOFT_RAMP_DISCHARGE(discharge),
    .REF_FROM_SOFT_RAMP(ref_ramp), .SINK_ALLOW(sink_ok),
    .EXT_CLK_MODE(ext_mode), .PLL_LOCKED(pll_lock),
    .HICCUP_ACTIVE(hiccup));

  analog_far_side far (
    .mclk(mclk), .hs_en(hs_en), .discharge(discharge),
    .osc_en(osc_en), .osc_tick(osc_tick), .peak(peak),
    .ramp_pg(ramp_pg), .ramp_low(ramp_low), .ramp_gnd(ramp_gnd));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic exp,
                       input logic got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic nw(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Bounded so a dead oscillator cannot stall the run
  task automatic tick(input int n);
    int i;
    repeat (n) begin
      i = 0;
      do begin
        @(negedge mclk);
        i++;
      end while (osc_tick !== 1'b1 && i < 60);
      check("tick seen", 1'b1, osc_tick);
    end
  endtask

  task automatic sw(input logic h, input logic l);
    check("high side", h, hs_en);
    check("low side", l, ls_en);
  endtask

  task automatic start_up();
    int i;
    i = 0;
    while (discharge !== 1'b0 && i < 300) begin
      @(negedge mclk);
      i++;
    end
    check("discharge end", 1'b0, discharge);
    check("ramp at ground", 1'b1, ramp_gnd);
    check("ref from ramp", 1'b1, ref_ramp);
    check("sink allowed", 1'b0, sink_ok);
    check("ok pulldown", 1'b1, ok_oe);
    nw(45);
    check("ref from ramp", 1'b0, ref_ramp);
    check("sink allowed", 1'b1, sink_ok);
    $display("test start_up done");
  endtask

  task automatic fb(input logic w, input logic l, input logic h);
    @(posedge mclk);
    fb_win  <= w;
    fb_low  <= l;
    fb_high <= h;
    nw(5);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic switching_test();
    tick(1);
    nw(2);
    sw(1'b1, 1'b0);
    nw(10);
    sw(1'b0, 1'b1);
    $display("test switching done");
  endtask

  task automatic pg_test();
    fb(1'b1, 1'b0, 1'b0);
    check("ok pulldown", 1'b0, ok_oe);
    check("ok level", 1'b0, ok_o);
    fb(1'b0, 1'b0, 1'b0);
    check("ok pulldown", 1'b0, ok_oe);
    fb(1'b0, 1'b1, 1'b0);
    check("ok pulldown", 1'b1, ok_oe);
    fb(1'b1, 1'b0, 1'b0);
    check("ok pulldown", 1'b0, ok_oe);
    fb(1'b0, 1'b0, 1'b1);
    check("ok pulldown", 1'b1, ok_oe);
    fb(1'b1, 1'b0, 1'b0);
    $display("test power_good done");
  endtask

  task automatic stop_test();
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      if (k == 0)
        en_ok <= 1'b0;
      else
        lockout <= 1'b1;
      nw(5);
      sw(1'b0, 1'b0);
      check("ok pulldown", 1'b1, ok_oe);
      check("discharge", 1'b1, discharge);
      @(posedge mclk);
      en_ok   <= 1'b1;
      lockout <= 1'b0;
      nw(1);
      start_up();
    end
    $display("test shutdown done");
  endtask

  task automatic overvolt_test();
    @(posedge mclk);
    overvolt <= 1'b1;
    tick(2);
    nw(3);
    check("high side", 1'b0, hs_en);
    @(posedge mclk);
    overvolt <= 1'b0;
    nw(8);
    check("high side", 1'b0, hs_en);
    tick(1);
    nw(3);
    check("high side", 1'b1, hs_en);
    $display("test overvolt done");
  endtask

  task automatic src_test();
    tick(1);
    nw(12);
    @(posedge mclk);
    ls_src <= 1'b1;
    tick(1);
    nw(3);
    sw(1'b0, 1'b1);
    @(posedge mclk);
    ls_src <= 1'b0;
    tick(1);
    nw(3);
    check("high side", 1'b1, hs_en);
    $display("test source_limit done");
  endtask

  task automatic sink_test();
    tick(1);
    nw(12);
    check("low side", 1'b1, ls_en);
    @(posedge mclk);
    ls_sink <= 1'b1;
    nw(1);
    @(posedge mclk);
    ls_sink <= 1'b0;
    nw(3);
    sw(1'b0, 1'b0);
    tick(1);
    nw(3);
    check("high side", 1'b1, hs_en);
    $display("test sink_limit done");
  endtask

  task automatic overload_test();
    tick(1);
    nw(2);
    @(posedge mclk);
    ovl <= 1'b1;
    tick(4);
    nw(3);
    check("hiccup", 1'b0, hiccup);
    tick(1);
    nw(3);
    check("hiccup", 1'b1, hiccup);
    sw(1'b0, 1'b0);
    @(posedge mclk);
    ovl <= 1'b0;
    tick(5);
    nw(3);
    check("hiccup", 1'b1, hiccup);
    check("discharge", 1'b1, discharge);
    start_up();
    check("hiccup", 1'b0, hiccup);
    $display("test overload done");
  endtask

  task automatic thermal_test();
    @(posedge mclk);
    hot <= 1'b1;
    nw(5);
    sw(1'b0, 1'b0);
    check("ok pulldown", 1'b1, ok_oe);
    tick(3);
    check("hiccup", 1'b0, hiccup);
    @(posedge mclk);
    hot <= 1'b0;
    nw(5);
    check("hiccup", 1'b1, hiccup);
    tick(5);
    nw(3);
    check("hiccup", 1'b1, hiccup);
    start_up();
    $display("test thermal done");
  endtask

  task automatic prebias_test();
    int i;
    @(posedge mclk);
    en_ok  <= 1'b0;
    ls_rev <= 1'b1;
    nw(5);
    @(posedge mclk);
    en_ok <= 1'b1;
    i = 0;
    while (discharge !== 1'b0 && i < 300) begin
      @(negedge mclk);
      i++;
    end
    check("discharge end", 1'b0, discharge);
    tick(1);
    nw(12);
    sw(1'b0, 1'b0);
    check("sink allowed", 1'b0, sink_ok);
    @(posedge mclk);
    ls_rev <= 1'b0;
    nw(45);
    check("sink allowed", 1'b1, sink_ok);
    $display("test prebias done");
  endtask

  task automatic ext_test();
    int i;
    @(posedge mclk);
    osc_en  <= 1'b0;
    sync_on <= 1'b1;
    nw(10);
    check("clock mode", 1'b1, ext_mode);
    nw(150);
    check("pll locked", 1'b1, pll_lock);
    i = 0;
    while (sync_pin !== 1'b1 && i < 40) begin
      @(negedge mclk);
      i++;
    end
    while (sync_pin !== 1'b0 && i < 80) begin
      @(negedge mclk);
      i++;
    end
    check("high side", 1'b0, hs_en);
    nw(6);
    check("high side", 1'b1, hs_en);
    $display("test clock_mode done");
  endtask

  always @(negedge mclk)
    if (hs_en === 1'b1 && ls_en === 1'b1)
      check("both enables", 1'b0, 1'b1);

  task automatic complete_run();
    $display("counts compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    complete_run();
  end

  initial begin
    repeat (10) @(posedge mclk);
    nrst  <= 1'b1;
    en_ok <= 1'b1;
    nw(3);
    start_up();
    switching_test();
    pg_test();
    stop_test();
    overvolt_test();
    src_test();
    sink_test();
    overload_test();
    thermal_test();
    prebias_test();
    ext_test();
    complete_run();
  end
endmodule
